// File: src/playback_seq_consts.svh
`ifndef PLAYBACK_SEQ_CONSTS_SVH
`define PLAYBACK_SEQ_CONSTS_SVH

// Register byte offsets.
`define ADDR_CMD 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_GAIN 12'h008
`define ADDR_ACTIVITY 12'h00c

// Command opcodes, upper nibble of the first byte.
`define OP_SILENCE 4'h7
`define OP_LOOP_SET 4'h8
`define OP_LOOP_CLEAR 4'h9
`define OP_CHAN_VOL 4'ha
// The overall volume command is a whole first byte.
`define OP_OVERALL_VOL 8'h08

// Gain reset values.
`define CHAN_GAIN_RESET 5'h00
`define OVERALL_GAIN_RESET 6'h23

// Silence step time and clock rate.
`define SILENCE_STEP_MS 4
`define CLK_FREQ_KHZ 250000

// Status and gain register field positions.
`define ST_READY_LSB 0
`define ST_BUSY_LSB 4
`define ST_CMD_BUSY_BIT 8
`define ST_PEND_BIT 9
`define GAIN_OVERALL_LSB 20

`endif

// File: src/playback_seq_pkg.sv
package playback_seq_pkg;

   typedef enum logic [2:0] {
      CH_IDLE,
      CH_ADDR,
      CH_PLAY,
      CH_PLAY_SIL_Q,
      CH_SIL,
      CH_SIL_NEXT,
      CH_LOOP
   } chan_state_t;

   typedef struct packed {
      chan_state_t st;
      logic [7:0] sil_code;
      logic [23:0] step_cnt;
      logic [7:0] sil_steps;
      logic [4:0] gain;
   } chan_t;

   // Events reported by the playback engine, one bit per channel, one-cycle pulses.
   typedef struct packed {
      logic [3:0] play_started;
      logic [3:0] addr_done;
      logic [3:0] phrase_end;
      logic [3:0] stopped;
   } engine_evt_t;

   typedef struct packed {
      logic [3:0] replay;
      logic [3:0] phrase_start;
      logic [3:0] silence_active;
   } engine_req_t;

   typedef struct packed {
      chan_t [3:0] ch;
      logic [5:0] overall_gain;
      logic pend;
      logic [7:0] pend_byte;
      logic power_ok_q;
      logic [3:0] replay;
      logic [3:0] phrase_start;
      logic [31:0] prdata;
      logic pslverr;
   } seq_state_t;

endpackage : playback_seq_pkg

// File: src/voice_playback_command_sequencer.sv
// How it works
// - Silence command: opcode, mask, then length.
// - Silence lasts (code plus one) times 4 ms.
// - Ready stays low until phrase finishes.
// - Phrase end starts silence, raises ready.
// - Play queued in silence drops ready.
// - Busy held through whole chained sequence.
// - Loop-set enters repeat on masked channels.
// - Ready held low while repeating.
// - Repeat replays phrase until clear or stop.
// - Stop cancels repeat mode.
// - Loop-clear releases repeat, raises ready.
// - Channel volume two bytes, refused unpowered.
// - Channel gain code resets to 00.
// - Overall volume two bytes, default 23h.
// - Overall gain survives stop, resets powered down.
// - Ready low during address fetch phase.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "playback_seq_consts.svh"

module voice_playback_command_sequencer #(
   parameter int unsigned STEP_CYCLES = `SILENCE_STEP_MS * `CLK_FREQ_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_ok,
   input wire playback_seq_pkg::engine_evt_t evt,
   output playback_seq_pkg::engine_req_t req,
   output logic [3:0] command_ready,
   output logic [3:0] playback_busy_n,
   output logic command_busy_n,
   output logic [19:0] channel_gain_code,
   output logic [5:0] overall_gain_code
);

   // The step counter is 24 bits wide: a step longer than 2**24 clocks would need a wider counter.
   localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);

   playback_seq_pkg::seq_state_t s_q;
   playback_seq_pkg::seq_state_t s_d;

   function automatic logic ready_of(input playback_seq_pkg::chan_state_t st);
      ready_of = (st == playback_seq_pkg::CH_IDLE) || (st == playback_seq_pkg::CH_PLAY) ||
                 (st == playback_seq_pkg::CH_SIL);
   endfunction : ready_of

   function automatic logic in_silence(input playback_seq_pkg::chan_state_t st);
      in_silence = (st == playback_seq_pkg::CH_SIL) || (st == playback_seq_pkg::CH_SIL_NEXT);
   endfunction : in_silence

   // Opcode decoders for the first-byte check; the silence and overall ones also dispatch a parked first byte.
   function automatic logic is_silence_op(input logic [7:0] op);
      is_silence_op = (op[7:4] == `OP_SILENCE);
   endfunction : is_silence_op

   function automatic logic is_chan_vol_op(input logic [7:0] op);
      is_chan_vol_op = (op[7:4] == `OP_CHAN_VOL);
   endfunction : is_chan_vol_op

   function automatic logic is_overall_vol_op(input logic [7:0] op);
      is_overall_vol_op = (op == `OP_OVERALL_VOL);
   endfunction : is_overall_vol_op

   function automatic logic takes_second_byte(input logic [7:0] op);
      takes_second_byte = is_silence_op(op) || is_chan_vol_op(op) || is_overall_vol_op(op);
   endfunction : takes_second_byte

   // Channels picked by a mask that stand in the state a command needs; the rest ignore it.
   function automatic logic [3:0] eligible(input logic [3:0] mask, input playback_seq_pkg::chan_t [3:0] ch,
                                           input playback_seq_pkg::chan_state_t need);
      eligible = 4'h0;
      for (int i = 0; i < 4; i++) begin
         eligible[i] = mask[i] && (ch[i].st == need);
      end
   endfunction : eligible

   function automatic logic [31:0] status_word(input logic [3:0] rdy, input logic [3:0] busy_n,
                                               input logic cmd_busy_n, input logic pend);
      status_word = 32'h0000_0000;
      status_word[`ST_READY_LSB +: 4] = rdy;
      status_word[`ST_BUSY_LSB +: 4] = busy_n;
      status_word[`ST_CMD_BUSY_BIT] = cmd_busy_n;
      status_word[`ST_PEND_BIT] = pend;
   endfunction : status_word

   logic [3:0] rdy_w;
   logic [3:0] busy_n_w;
   logic [3:0] sil_w;
   logic [19:0] gains_w;
   logic addr_busy_w;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         rdy_w[i] = ready_of(s_q.ch[i].st);
         busy_n_w[i] = (s_q.ch[i].st == playback_seq_pkg::CH_IDLE);
         sil_w[i] = in_silence(s_q.ch[i].st);
         gains_w[i*5 +: 5] = s_q.ch[i].gain;
      end
      // Any channel in its address fetch holds the shared command-busy flag low.
      addr_busy_w = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (s_q.ch[i].st == playback_seq_pkg::CH_ADDR) begin
            addr_busy_w = 1'b1;
         end
      end
   end

   always_comb begin
      logic wr_cmd;
      logic setup;
      logic [7:0] b;
      logic [3:0] m;
      logic [3:0] sel_play;
      logic [3:0] sel_loop;
      wr_cmd = 1'b0;
      setup = 1'b0;
      b = 8'h00;
      m = 4'h0;
      sel_play = 4'h0;
      sel_loop = 4'h0;
      s_d = s_q;
      s_d.replay = 4'h0;
      s_d.phrase_start = 4'h0;
      // The power-up edge is taken against the registered level, so the channel gains also clear once after reset.
      s_d.power_ok_q = power_ok;
      setup = psel && !penable;
      wr_cmd = psel && penable && pwrite && (paddr == `ADDR_CMD);
      b = pwdata[7:0];
      m = s_q.pend ? s_q.pend_byte[3:0] : pwdata[3:0];
      sel_play = eligible(m, s_q.ch, playback_seq_pkg::CH_PLAY);
      sel_loop = eligible(m, s_q.ch, playback_seq_pkg::CH_LOOP);

      // Read data is captured in the setup cycle so that the access phase needs no wait.
      if (setup) begin
         s_d.pslverr = 1'b0;
         s_d.prdata = 32'h0000_0000;
         if (paddr == `ADDR_CMD) begin
            s_d.prdata[7:0] = s_q.pend_byte;
         end else if (paddr == `ADDR_STATUS) begin
            s_d.prdata = status_word(rdy_w, busy_n_w, !addr_busy_w, s_q.pend);
         end else if (paddr == `ADDR_GAIN) begin
            s_d.prdata[19:0] = gains_w;
            s_d.prdata[`GAIN_OVERALL_LSB +: 6] = s_q.overall_gain;
         end else if (paddr == `ADDR_ACTIVITY) begin
            s_d.prdata[3:0] = sil_w;
         end else begin
            s_d.pslverr = 1'b1;
         end
      end

      if (wr_cmd) begin
         if (s_q.pend) begin
            // A parked first byte claims this write whatever it holds, so a refused operand is still consumed.
            s_d.pend = 1'b0;
            if (is_silence_op(s_q.pend_byte)) begin
               for (int i = 0; i < 4; i++) begin
                  if (sel_play[i]) begin
                     s_d.ch[i].st = playback_seq_pkg::CH_PLAY_SIL_Q;
                     s_d.ch[i].sil_code = b;
                  end
               end
            end else if (is_overall_vol_op(s_q.pend_byte)) begin
               if (power_ok) begin
                  s_d.overall_gain = b[5:0];
               end
            end else begin
               for (int i = 0; i < 4; i++) begin
                  if (m[i] && power_ok) begin
                     s_d.ch[i].gain = b[4:0];
                  end
               end
            end
         end else if (takes_second_byte(b)) begin
            s_d.pend = 1'b1;
            s_d.pend_byte = b;
         end else if (b[7:4] == `OP_LOOP_SET) begin
            for (int i = 0; i < 4; i++) begin
               if (sel_play[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_LOOP;
               end
            end
         end else if (b[7:4] == `OP_LOOP_CLEAR) begin
            for (int i = 0; i < 4; i++) begin
               if (sel_loop[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_PLAY;
               end
            end
         end
      end

      // Engine events follow the commands so a same-cycle phrase end sees a freshly queued silence.
      for (int i = 0; i < 4; i++) begin
         case (s_d.ch[i].st)
            playback_seq_pkg::CH_IDLE: begin
               if (evt.play_started[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_ADDR;
               end
            end
            playback_seq_pkg::CH_ADDR: begin
               if (evt.addr_done[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_PLAY;
               end
            end
            playback_seq_pkg::CH_PLAY: begin
               if (evt.phrase_end[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_IDLE;
               end
            end
            playback_seq_pkg::CH_PLAY_SIL_Q: begin
               if (evt.phrase_end[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_SIL;
                  s_d.ch[i].step_cnt = 24'h00_0000;
                  s_d.ch[i].sil_steps = 8'h00;
               end
            end
            playback_seq_pkg::CH_SIL, playback_seq_pkg::CH_SIL_NEXT: begin
               if (s_d.ch[i].st == playback_seq_pkg::CH_SIL && evt.play_started[i]) begin
                  s_d.ch[i].st = playback_seq_pkg::CH_SIL_NEXT;
               end
               if (s_q.ch[i].step_cnt == STEP_LAST) begin
                  s_d.ch[i].step_cnt = 24'h00_0000;
                  if (s_q.ch[i].sil_steps == s_q.ch[i].sil_code) begin
                     // The silence is over after sil_code plus one whole steps.
                     if (s_d.ch[i].st == playback_seq_pkg::CH_SIL_NEXT) begin
                        s_d.ch[i].st = playback_seq_pkg::CH_PLAY;
                        s_d.phrase_start[i] = 1'b1;
                     end else begin
                        s_d.ch[i].st = playback_seq_pkg::CH_IDLE;
                     end
                  end else begin
                     s_d.ch[i].sil_steps = s_q.ch[i].sil_steps + 8'h01;
                  end
               end else begin
                  s_d.ch[i].step_cnt = s_q.ch[i].step_cnt + 24'h00_0001;
               end
            end
            playback_seq_pkg::CH_LOOP: begin
               if (evt.phrase_end[i]) begin
                  s_d.replay[i] = 1'b1;
               end
            end
            default: begin
               s_d.ch[i].st = playback_seq_pkg::CH_IDLE;
            end
         endcase
         // A stop overrides any state change and drops repeat mode with it; a replay or start pulse raised in the same cycle still goes out.
         if (evt.stopped[i]) begin
            s_d.ch[i].st = playback_seq_pkg::CH_IDLE;
         end
         if (power_ok && !s_q.power_ok_q) begin
            s_d.ch[i].gain = `CHAN_GAIN_RESET;
         end
      end

      if (!power_ok) begin
         s_d.overall_gain = `OVERALL_GAIN_RESET;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         for (int i = 0; i < 4; i++) begin
            s_q.ch[i].st <= playback_seq_pkg::CH_IDLE;
            s_q.ch[i].gain <= `CHAN_GAIN_RESET;
         end
         s_q.overall_gain <= `OVERALL_GAIN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = s_q.pslverr && psel && penable;
   assign command_ready = rdy_w;
   assign playback_busy_n = busy_n_w;
   assign command_busy_n = !addr_busy_w;
   assign channel_gain_code = gains_w;
   assign overall_gain_code = s_q.overall_gain;
   assign req.replay = s_q.replay;
   assign req.phrase_start = s_q.phrase_start;
   assign req.silence_active = sil_w;

endmodule : voice_playback_command_sequencer

`default_nettype wire

// File: dv/seq_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module seq_checker #(parameter int unsigned STEP_CYCLES = 8) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pslverr,
   input wire logic power_ok,
   input wire playback_seq_pkg::engine_evt_t evt,
   input wire playback_seq_pkg::engine_req_t req,
   input wire logic [3:0] command_ready,
   input wire logic [3:0] playback_busy_n,
   input wire logic command_busy_n,
   input wire logic [19:0] channel_gain_code,
   input wire logic [5:0] overall_gain_code
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ADDR_READY: assert property (evt.play_started[0] && !evt.stopped[0] |=> !command_ready[0])
      else $error("ready high after start");
   AST_ADDR_BUSY: assert property (evt.play_started[0] && playback_busy_n[0] && !evt.stopped[0] |=> !command_busy_n)
      else $error("command busy not low");
   AST_REPLAY: assert property (req.replay[1] |-> $past(evt.phrase_end[1]) && !command_ready[1])
      else $error("bad replay");
   AST_STOP: assert property (evt.stopped[1] |=> command_ready[1] && playback_busy_n[1])
      else $error("stop left channel busy");
   AST_SIL_START: assert property (req.phrase_start[0] |-> $past(req.silence_active[0]))
      else $error("start without silence");
   AST_OVERALL_PWR: assert property (!power_ok |=> overall_gain_code == 6'h23)
      else $error("overall gain kept unpowered");
   AST_CHGAIN_PWRUP: assert property ($rose(power_ok) |=> channel_gain_code == 20'h0)
      else $error("gains kept at power up");
   AST_VOL_LOCK: assert property (!power_ok |=> $stable(channel_gain_code))
      else $error("gain changed unpowered");
   cover property (req.replay[1]);
   cover property (req.phrase_start[0]);
   cover property (pslverr);
endmodule : seq_checker
bind voice_playback_command_sequencer seq_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_u (.*);
`default_nettype wire

// File: dv/playback_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module playback_engine_model #(parameter int PLEN = 60) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] go,
   input wire logic [3:0] halt,
   input wire playback_seq_pkg::engine_req_t req,
   output var playback_seq_pkg::engine_evt_t evt
);
   int cnt [4];
   // A start given during silence is only announced; the phrase waits for the start pulse.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt <= '0;
         cnt <= '{default: 0};
      end else begin
         evt <= '0;
         for (int i = 0; i < 4; i++) begin
            if (halt[i]) begin
               evt.stopped[i] <= 1'b1;
               cnt[i] <= 0;
            end else if (go[i]) begin
               evt.play_started[i] <= 1'b1;
               cnt[i] <= req.silence_active[i] ? 0 : 1;
            end else if (req.replay[i] || req.phrase_start[i]) begin
               cnt[i] <= 4;
            end else if (cnt[i] != 0) begin
               evt.addr_done[i] <= cnt[i] == 3;
               evt.phrase_end[i] <= cnt[i] == PLEN;
               cnt[i] <= cnt[i] == PLEN ? 0 : cnt[i] + 1;
            end
         end
      end
   end
endmodule : playback_engine_model
`default_nettype wire

// File: dv/voice_playback_command_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module voice_playback_command_sequencer_test;
   localparam int STEP = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, power_ok, command_busy_n, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] go, halt, command_ready, playback_busy_n;
   logic [19:0] channel_gain_code;
   logic [5:0] overall_gain_code;
   playback_seq_pkg::engine_evt_t evt;
   playback_seq_pkg::engine_req_t req;
   int failures = 0;
   int num_checks = 0;
   time t0;
   voice_playback_command_sequencer #(.STEP_CYCLES(STEP)) dut_u (.*);
   playback_engine_model #(.PLEN(60)) eng_u (.*);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The request stands until the edge at which pready is sampled high; the answer is taken there.
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input logic [7:0] b);
      apb(1'b1, 12'h000, {24'h0, b});
   endtask : cmd
   task automatic pulse(input logic [3:0] g, input logic [3:0] h);
      @(posedge pclk);
      go <= g;
      halt <= h;
      @(posedge pclk);
      go <= 4'h0;
      halt <= 4'h0;
   endtask : pulse
   task automatic wait_rdy(input int c, input logic v);
      for (int k = 0; k < 500 && command_ready[c] !== v; k++) @(negedge pclk);
   endtask : wait_rdy
   initial begin
      {psel, penable, pwrite, paddr, pwdata, go, halt} = '0;
      power_ok = 1'b1;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk("status", 32'h1ff, rd);
      chk("pready", 32'h1, {31'h0, pready});
      apb(1'b0, 12'h008, 32'h0);
      chk("gain", 32'h0230_0000, rd);
      $display("reset test done");
      pulse(4'h1, 4'h0);
      wait_rdy(0, 1'b0);
      chk("cmd busy", 32'h0, {31'h0, command_busy_n});
      wait_rdy(0, 1'b1);
      cmd(8'h71);
      cmd(8'h04);
      @(negedge pclk);
      chk("ready hold", 32'h0, {31'h0, command_ready[0]});
      @(posedge pclk iff evt.phrase_end[0]);
      t0 = $time;
      wait_rdy(0, 1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      chk("silence", 32'h1, rd);
      pulse(4'h1, 4'h0);
      wait_rdy(0, 1'b0);
      chk("queued", 32'h0, {31'h0, command_ready[0]});
      @(posedge pclk iff req.phrase_start[0]);
      // The start pulse launched as the silence ends is seen one edge later.
      chk("length", 32'((4 + 1) * STEP + 1), 32'(($time - t0) / 4));
      @(negedge pclk);
      chk("chain", 32'hef, {24'h0, playback_busy_n, command_ready});
      @(posedge pclk iff evt.phrase_end[0]);
      @(negedge pclk);
      chk("end", 32'hff, {24'h0, playback_busy_n, command_ready});
      $display("silence test done");
      pulse(4'h2, 4'h0);
      wait_rdy(1, 1'b0);
      wait_rdy(1, 1'b1);
      cmd(8'h82);
      @(negedge pclk);
      chk("loop", 32'h0, {31'h0, command_ready[1]});
      repeat (2) @(posedge pclk iff req.replay[1]);
      cmd(8'h92);
      @(negedge pclk);
      chk("clear", 32'h1, {31'h0, command_ready[1]});
      cmd(8'h82);
      pulse(4'h0, 4'h2);
      repeat (2) @(negedge pclk);
      chk("stop", 32'hff, {24'h0, playback_busy_n, command_ready});
      @(negedge pclk iff playback_busy_n[1] === 1'b1);
      pulse(4'h2, 4'h0);
      @(posedge pclk iff evt.phrase_end[1]);
      @(negedge pclk);
      chk("once", 32'hff, {24'h0, playback_busy_n, command_ready});
      $display("loop test done");
      cmd(8'ha3);
      cmd(8'h1f);
      cmd(8'h08);
      cmd(8'h3f);
      pulse(4'h0, 4'h1);
      repeat (2) @(negedge pclk);
      chk("ch gain", 32'h3ff, {12'h0, channel_gain_code});
      chk("overall", 32'h3f, {26'h0, overall_gain_code});
      @(posedge pclk);
      power_ok <= 1'b0;
      cmd(8'ha4);
      cmd(8'h05);
      @(negedge pclk);
      chk("ch gain off", 32'h3ff, {12'h0, channel_gain_code});
      chk("overall off", 32'h23, {26'h0, overall_gain_code});
      @(posedge pclk);
      power_ok <= 1'b1;
      repeat (3) @(negedge pclk);
      chk("ch gain up", 32'h0, {12'h0, channel_gain_code});
      $display("volume test done");
      cmd(8'h74);
      cmd(8'h10);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("ignored", 32'h1ff, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      $display("refusal test done");
      test_done();
   end
   initial begin
      #100000;
      failures++;
      test_done();
   end
endmodule : voice_playback_command_sequencer_test
`default_nettype wire
